// File: tac_fsm.sv
/*
 * tac_fsm: command decoder and state machine for the anticollision and selection phase.
 * assumes frames arrive one per frame_valid_in pulse, already de-framed, with crc_ok set
 * by the upstream checker; reset_n_in is the field-loss reset.
 */
// Overview of operation
// - begin-inventory in Ready: go Inventory, draw new 8-bit id, reply with it
// - begin-inventory reply never depends on the slot draw
// - slot-round acted on only in Inventory, ignored elsewhere
// - slot-round replaces low four id bits with new random 0..15
// - slot draw held until next slot-round or begin-inventory or reset
// - after slot-round reply with id only if new slot is zero
// - slot-poll byte: low nibble six, high nibble index 1..15
// - slot-poll in Inventory: reply id on slot match, else silent
// - before choose only inventory commands accepted; choose enters Selected
// - choose with own id replies all eight id bits
// - Selected tag receiving choose with other id goes Deselected
// - finish in Selected enters Deactivated, decoding stops until reset
// - finish gives no reply; ignored outside Selected
// - back-to-inventory in Selected returns to Inventory
// - back-to-inventory gives no reply; ignored outside Selected
// - after reset start Ready, answer only begin-inventory
module tac_fsm (
    input  wire logic               clk_in,
    input  wire logic               reset_n_in,
    input  wire logic               frame_valid_in,
    input  wire tac_pkg::tac_frame_s frame_in,
    output logic                    reply_valid_out,
    output logic [7:0]              reply_data_out,
    output tac_pkg::tac_state_e     state_out,
    output logic [7:0]              session_tag_id_out
);

    tac_pkg::tac_state_e state_q;
    tac_pkg::tac_state_e state_d;
    logic [7:0]          session_tag_id_q;
    logic [7:0]          session_tag_id_d;
    logic                reply_valid_q;
    logic                reply_valid_d;
    logic [7:0]          reply_data_q;
    logic [7:0]          rnd;
    logic                ok;
    logic                is_begin;
    logic                is_round;
    logic                is_poll;
    logic [3:0]          poll_slot_field;
    logic [3:0]          new_slot;

    tac_lfsr u_lfsr (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .rnd_out    (rnd)
    );

    assign ok = frame_valid_in && frame_in.crc_ok;
    assign is_begin = frame_in.cmd == tac_pkg::TAC_CMD_INV_PREFIX
                      && frame_in.arg == tac_pkg::TAC_CMD_INV_BEGIN;
    assign is_round = frame_in.cmd == tac_pkg::TAC_CMD_INV_PREFIX
                      && frame_in.arg == tac_pkg::TAC_CMD_INV_ROUND;
    // poll byte decode, index zero belongs to slot-round
    assign poll_slot_field = frame_in.cmd[7:4];
    assign is_poll = frame_in.cmd[3:0] == tac_pkg::TAC_POLL_LOW_NIBBLE
                     && poll_slot_field != tac_pkg::TAC_SLOT_ZERO;
    assign new_slot = rnd[tac_pkg::TAC_SLOT_LSB +: tac_pkg::TAC_SLOT_W];

    always_comb begin
        state_d          = state_q;
        session_tag_id_d = session_tag_id_q;
        reply_valid_d    = 1'b0;
        if (ok) begin
            case (state_q)
                tac_pkg::TAC_ST_READY: begin
                    if (is_begin) begin
                        // fresh id and reply; slot not consulted
                        state_d          = tac_pkg::TAC_ST_INVENTORY;
                        session_tag_id_d = rnd;
                        reply_valid_d    = 1'b1;
                    end
                end
                tac_pkg::TAC_ST_INVENTORY,
                tac_pkg::TAC_ST_DESELECTED: begin
                    // round and poll only act in inventory
                    if (state_q == tac_pkg::TAC_ST_INVENTORY && is_round) begin
                        // low nibble redraw; reply only on slot zero
                        session_tag_id_d = {session_tag_id_q[7:4], new_slot};
                        reply_valid_d    = new_slot == tac_pkg::TAC_SLOT_ZERO;
                    end else if (state_q == tac_pkg::TAC_ST_INVENTORY && is_poll) begin
                        reply_valid_d = poll_slot_field == session_tag_id_q[3:0];
                    end else if (frame_in.cmd == tac_pkg::TAC_CMD_CHOOSE
                                 && frame_in.arg == session_tag_id_q) begin
                        state_d       = tac_pkg::TAC_ST_SELECTED;
                        reply_valid_d = 1'b1;
                    end
                end
                tac_pkg::TAC_ST_SELECTED: begin
                    if (frame_in.cmd == tac_pkg::TAC_CMD_CHOOSE) begin
                        if (frame_in.arg == session_tag_id_q) begin
                            reply_valid_d = 1'b1;
                        end else begin
                            state_d = tac_pkg::TAC_ST_DESELECTED;
                        end
                    end else if (frame_in.cmd == tac_pkg::TAC_CMD_FINISH) begin
                        state_d = tac_pkg::TAC_ST_DEACTIVATED;
                    end else if (frame_in.cmd == tac_pkg::TAC_CMD_BACK_TO_INV) begin
                        state_d = tac_pkg::TAC_ST_INVENTORY;
                    end
                end
                tac_pkg::TAC_ST_DEACTIVATED: begin
                    state_d = tac_pkg::TAC_ST_DEACTIVATED;
                end
                default: begin
                    state_d = tac_pkg::TAC_ST_READY;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            state_q <= tac_pkg::TAC_ST_READY;
        end else begin
            state_q <= state_d;
        end
    end

    // id only changes on draw commands
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            session_tag_id_q <= tac_pkg::TAC_ID_RESET;
        end else begin
            session_tag_id_q <= session_tag_id_d;
        end
    end

    // reply carries the post-update id so a fresh draw is what goes out
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            reply_valid_q <= 1'b0;
            reply_data_q  <= tac_pkg::TAC_ID_RESET;
        end else begin
            reply_valid_q <= reply_valid_d;
            if (reply_valid_d) begin
                reply_data_q <= session_tag_id_d;
            end
        end
    end

    assign reply_valid_out    = reply_valid_q;
    assign reply_data_out     = reply_data_q;
    assign state_out          = state_q;
    assign session_tag_id_out = session_tag_id_q;

    ready_only_begin_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        state_q == tac_pkg::TAC_ST_READY && ok && !is_begin |=> !reply_valid_q
            && state_q == tac_pkg::TAC_ST_READY)
        else $error("ready state reacted to a non-begin command");

    begin_reply_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        state_q == tac_pkg::TAC_ST_READY && ok && is_begin |=> reply_valid_q
            && state_q == tac_pkg::TAC_ST_INVENTORY && reply_data_q == session_tag_id_q)
        else $error("begin-inventory did not enter inventory with reply");

    round_redraw_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        state_q == tac_pkg::TAC_ST_INVENTORY && ok && is_round |=>
            session_tag_id_q[7:4] == $past(session_tag_id_q[7:4])
            && reply_valid_q == (session_tag_id_q[3:0] == tac_pkg::TAC_SLOT_ZERO))
        else $error("slot-round draw or zero-slot reply wrong");

    id_hold_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !(ok && (is_begin || is_round)) |=> $stable(session_tag_id_q))
        else $error("session id changed without a draw command");

    poll_match_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        state_q == tac_pkg::TAC_ST_INVENTORY && ok && is_poll |=>
            reply_valid_q == ($past(poll_slot_field) == session_tag_id_q[3:0]))
        else $error("slot-poll reply does not follow slot match");

    sequence sel_foreign_s;
        state_q == tac_pkg::TAC_ST_SELECTED && ok
            && frame_in.cmd == tac_pkg::TAC_CMD_CHOOSE && frame_in.arg != session_tag_id_q;
    endsequence
    choose_foreign_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        sel_foreign_s |=> state_q == tac_pkg::TAC_ST_DESELECTED && !reply_valid_q)
        else $error("foreign choose did not deselect");

    deact_lock_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        state_q == tac_pkg::TAC_ST_DEACTIVATED |=> state_q == tac_pkg::TAC_ST_DEACTIVATED
            && !reply_valid_q)
        else $error("deactivated tag left its state or replied");

    silent_cmds_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        ok && (frame_in.cmd == tac_pkg::TAC_CMD_BACK_TO_INV
            || frame_in.cmd == tac_pkg::TAC_CMD_FINISH) |=> !reply_valid_q)
        else $error("finish or back-to-inventory produced a reply");

    bad_crc_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        frame_valid_in && !frame_in.crc_ok |=> $stable(state_q) && !reply_valid_q)
        else $error("bad checksum frame changed state or replied");

    sequence choose_own_s;
        ok && frame_in.cmd == tac_pkg::TAC_CMD_CHOOSE && frame_in.arg == session_tag_id_q
            && (state_q == tac_pkg::TAC_ST_INVENTORY || state_q == tac_pkg::TAC_ST_SELECTED
            || state_q == tac_pkg::TAC_ST_DESELECTED);
    endsequence
    choose_own_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        choose_own_s |=> reply_valid_q && state_q == tac_pkg::TAC_ST_SELECTED
            && reply_data_q == $past(session_tag_id_q))
        else $error("own-id choose did not select and echo the id");

    sequence sel_finish_s;
        state_q == tac_pkg::TAC_ST_SELECTED && ok && frame_in.cmd == tac_pkg::TAC_CMD_FINISH;
    endsequence
    finish_enter_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        sel_finish_s |=> state_q == tac_pkg::TAC_ST_DEACTIVATED)
        else $error("finish in selected did not deactivate");

    back_to_inv_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        state_q == tac_pkg::TAC_ST_SELECTED && ok
            && frame_in.cmd == tac_pkg::TAC_CMD_BACK_TO_INV |=> state_q == tac_pkg::TAC_ST_INVENTORY)
        else $error("back-to-inventory did not return to inventory");

    unsel_ignore_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        state_q != tac_pkg::TAC_ST_SELECTED && ok && (frame_in.cmd == tac_pkg::TAC_CMD_FINISH
            || frame_in.cmd == tac_pkg::TAC_CMD_BACK_TO_INV)
            |=> $stable(state_q) && $stable(session_tag_id_q))
        else $error("finish or back-to-inventory acted outside selected");

    round_ignore_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        state_q != tac_pkg::TAC_ST_INVENTORY && ok && is_round
            |=> $stable(state_q) && $stable(session_tag_id_q) && !reply_valid_q)
        else $error("slot-round acted outside inventory");

endmodule // tac_fsm

// File: tac_pkg.sv
/*
 * tac_pkg: shared constants and carrier types of the tag anticollision command interpreter.
 * assumes a frame decoder upstream hands over whole, checksum-checked command frames.
 */
package tac_pkg;

    // first byte of the two-byte inventory commands
    localparam logic [7:0] TAC_CMD_INV_PREFIX   = 8'h06;
    // second byte selecting begin-inventory
    localparam logic [7:0] TAC_CMD_INV_BEGIN    = 8'h00;
    // second byte selecting slot-round
    localparam logic [7:0] TAC_CMD_INV_ROUND    = 8'h04;
    // fixed low nibble of the slot-poll byte
    localparam logic [3:0] TAC_POLL_LOW_NIBBLE  = 4'h6;
    localparam logic [7:0] TAC_CMD_CHOOSE       = 8'h0E;
    localparam logic [7:0] TAC_CMD_FINISH       = 8'h0F;
    localparam logic [7:0] TAC_CMD_BACK_TO_INV  = 8'h0C;

    // position of the slot draw inside the session identifier
    localparam int         TAC_SLOT_LSB         = 0;
    localparam int         TAC_SLOT_W           = 4;
    localparam logic [3:0] TAC_SLOT_ZERO        = 4'h0;

    localparam logic [7:0] TAC_ID_RESET         = 8'h00;
    localparam logic [7:0] TAC_LFSR_SEED        = 8'hA5;
    // lfsr feedback taps x^8+x^6+x^5+x^4+1
    localparam logic [7:0] TAC_LFSR_TAPS        = 8'hB8;

    typedef enum logic [4:0] {
        TAC_ST_READY       = 5'h01,
        TAC_ST_INVENTORY   = 5'h02,
        TAC_ST_SELECTED    = 5'h04,
        TAC_ST_DESELECTED  = 5'h08,
        TAC_ST_DEACTIVATED = 5'h10
    } tac_state_e;

    // one received frame: command, optional argument, checksum verdict
    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] arg;
        logic       crc_ok;
    } tac_frame_s;

endpackage : tac_pkg

// File: tac_lfsr.sv
/*
 * tac_lfsr: free-running galois lfsr used as the random source.
 * assumes a synchronous active-low reset; advances on every clock.
 */
module tac_lfsr (
    input  wire logic       clk_in,
    input  wire logic       reset_n_in,
    output logic [7:0]      rnd_out
);

    logic [7:0] lfsr_q;

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            lfsr_q <= tac_pkg::TAC_LFSR_SEED;
        end else if (lfsr_q[0]) begin
            lfsr_q <= (lfsr_q >> 1) ^ tac_pkg::TAC_LFSR_TAPS;
        end else begin
            lfsr_q <= lfsr_q >> 1;
        end
    end

    assign rnd_out = lfsr_q;

endmodule // tac_lfsr

// File: tac_reader.sv
/*
 * tac_reader: behavioural proximity reader that sends whole command frames.
 * assumes the tag takes a frame on a valid edge and registers its answer on that same edge.
 */
module tac_reader (
    input  wire logic          clk_in,
    input  wire logic          reply_valid_in,
    input  wire logic [7:0]    reply_data_in,
    output logic               frame_valid_out,
    output tac_pkg::tac_frame_s frame_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       got;
    logic [7:0] heard;

    initial begin
        frame_valid_out = 1'b0;
        frame_out       = '0;
        got             = 1'b0;
        heard           = 8'h00;
    end

    // one frame held until its take edge, then read the reply 1ns after that edge
    task automatic send(input logic [7:0] cmd, input logic [7:0] arg, input logic ok);
        @(posedge clk_in);
        frame_valid_out <= 1'b1;
        frame_out       <= '{cmd: cmd, arg: arg, crc_ok: ok};
        @(posedge clk_in);
        frame_valid_out <= 1'b0;
        // released lines flip so stale content never looks valid
        frame_out       <= ~frame_out;
        #1;
        got   = reply_valid_in;
        heard = reply_data_in;
    endtask
endmodule // tac_reader

// File: tb_tac_fsm.sv
/*
 * tb_tac_fsm: self-checking bench of the anticollision state machine.
 * assumes tac_pkg, tac_lfsr and tac_fsm are compiled first.
 */
module tb_tac_fsm;
    timeunit 1ns;
    timeprecision 1ps;

    logic                clk_in;
    logic                reset_n_in;
    logic                frame_valid;
    tac_pkg::tac_frame_s frame;
    logic                reply_valid;
    logic [7:0]          reply_data;
    tac_pkg::tac_state_e state;
    logic [7:0]          tag_id;
    logic [7:0]          id;
    logic [7:0]          rnd_ref;
    logic [7:0]          draw_ref;
    int                  num_errors = 0;
    int                  num_checks = 0;
    int                  cycles = 0;

    tac_fsm u_tac_fsm (
        .clk_in            (clk_in),
        .reset_n_in        (reset_n_in),
        .frame_valid_in    (frame_valid),
        .frame_in          (frame),
        .reply_valid_out   (reply_valid),
        .reply_data_out    (reply_data),
        .state_out         (state),
        .session_tag_id_out(tag_id)
    );

    tac_reader u_tac_reader (
        .clk_in         (clk_in),
        .reply_valid_in (reply_valid),
        .reply_data_in  (reply_data),
        .frame_valid_out(frame_valid),
        .frame_out      (frame)
    );

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // reference random source from package constants; draw_ref is the value at the last edge
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            rnd_ref <= tac_pkg::TAC_LFSR_SEED;
        end else if (rnd_ref[0]) begin
            rnd_ref <= (rnd_ref >> 1) ^ tac_pkg::TAC_LFSR_TAPS;
        end else begin
            rnd_ref <= rnd_ref >> 1;
        end
        draw_ref <= rnd_ref;
    end

    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_st(input tac_pkg::tac_state_e exp);
        num_checks++;
        if (state !== exp) begin
            num_errors++;
            $display("ERROR state expected %h seen %h", exp, state);
        end
    endtask

    task automatic xfer(input logic [7:0] c, input logic [7:0] a, input logic ok,
                        input logic rep, input tac_pkg::tac_state_e st);
        u_tac_reader.send(c, a, ok);
        chk8("reply_valid", {7'h00, rep}, {7'h00, u_tac_reader.got});
        chk_st(st);
    endtask

    task automatic do_reset();
        @(posedge clk_in);
        reset_n_in <= 1'b0;
        repeat (8) @(posedge clk_in);
        reset_n_in <= 1'b1;
        #1;
        chk_st(tac_pkg::TAC_ST_READY);
        chk8("id_reset", 8'h00, tag_id);
        chk8("data_reset", 8'h00, reply_data);
        chk8("valid_reset", 8'h00, {7'h00, reply_valid});
    endtask

    task automatic t_ready();
        xfer(8'h06, 8'h04, 1'b1, 1'b0, tac_pkg::TAC_ST_READY);
        xfer(8'h16, 8'h00, 1'b1, 1'b0, tac_pkg::TAC_ST_READY);
        xfer(8'h0E, 8'h00, 1'b1, 1'b0, tac_pkg::TAC_ST_READY);
        xfer(8'h0F, 8'h00, 1'b1, 1'b0, tac_pkg::TAC_ST_READY);
        xfer(8'h0C, 8'h00, 1'b1, 1'b0, tac_pkg::TAC_ST_READY);
        xfer(8'h06, 8'h00, 1'b0, 1'b0, tac_pkg::TAC_ST_READY);
        xfer(8'h06, 8'h00, 1'b1, 1'b1, tac_pkg::TAC_ST_INVENTORY);
        id = draw_ref;
        chk8("begin_reply", id, u_tac_reader.heard);
        chk8("begin_id", id, tag_id);
    endtask

    // rounds until both a zero and a non-zero slot have turned up; every non-zero round polls all fifteen slots
    task automatic t_round();
        logic [3:0] s;
        logic [3:0] k;
        bit         z = 1'b0;
        bit         nz = 1'b0;
        for (int i = 0; i < 255 && !(z && nz); i++) begin
            u_tac_reader.send(8'h06, 8'h04, 1'b1);
            s = draw_ref[3:0];
            id = {id[7:4], s};
            chk8("round_id", id, tag_id);
            chk8("round_reply", {7'h00, s == 4'h0}, {7'h00, u_tac_reader.got});
            if (s == 4'h0) begin
                z = 1'b1;
                chk8("round_data", id, u_tac_reader.heard);
                xfer(8'h06, 8'h01, 1'b1, 1'b0, tac_pkg::TAC_ST_INVENTORY);
            end else begin
                nz = 1'b1;
                for (int j = 1; j < 16; j++) begin
                    k = 4'(j);
                    xfer({k, 4'h6}, 8'h00, 1'b1, k == s, tac_pkg::TAC_ST_INVENTORY);
                    if (k == s) begin
                        chk8("poll_data", id, u_tac_reader.heard);
                    end
                end
            end
        end
        chk8("slots_seen", 8'h01, {7'h00, z && nz});
    endtask

    task automatic t_select();
        xfer(8'h0E, ~id, 1'b1, 1'b0, tac_pkg::TAC_ST_INVENTORY);
        xfer(8'h0E, id, 1'b1, 1'b1, tac_pkg::TAC_ST_SELECTED);
        chk8("choose_echo", id, u_tac_reader.heard);
        xfer(8'h06, 8'h04, 1'b1, 1'b0, tac_pkg::TAC_ST_SELECTED);
        xfer(8'h0C, 8'h00, 1'b1, 1'b0, tac_pkg::TAC_ST_INVENTORY);
        u_tac_reader.send(8'h06, 8'h04, 1'b1);
        id = {id[7:4], draw_ref[3:0]};
        chk8("redraw_id", id, tag_id);
        chk8("redraw_reply", {7'h00, id[3:0] == 4'h0}, {7'h00, u_tac_reader.got});
        xfer(8'h0E, id, 1'b1, 1'b1, tac_pkg::TAC_ST_SELECTED);
        chk8("choose_data", id, u_tac_reader.heard);
        xfer(8'h0E, ~id, 1'b1, 1'b0, tac_pkg::TAC_ST_DESELECTED);
        xfer(8'h06, 8'h04, 1'b1, 1'b0, tac_pkg::TAC_ST_DESELECTED);
        xfer({id[3:0], 4'h6}, 8'h00, 1'b1, 1'b0, tac_pkg::TAC_ST_DESELECTED);
        xfer(8'h0F, 8'h00, 1'b1, 1'b0, tac_pkg::TAC_ST_DESELECTED);
        xfer(8'h0C, 8'h00, 1'b1, 1'b0, tac_pkg::TAC_ST_DESELECTED);
        xfer(8'h0E, id, 1'b1, 1'b1, tac_pkg::TAC_ST_SELECTED);
        xfer(8'h0E, id, 1'b1, 1'b1, tac_pkg::TAC_ST_SELECTED);
        chk8("reselect_data", id, u_tac_reader.heard);
        xfer(8'h0F, 8'h00, 1'b0, 1'b0, tac_pkg::TAC_ST_SELECTED);
        xfer(8'h0F, 8'h00, 1'b1, 1'b0, tac_pkg::TAC_ST_DEACTIVATED);
        xfer(8'h0E, id, 1'b1, 1'b0, tac_pkg::TAC_ST_DEACTIVATED);
        xfer(8'h0C, 8'h00, 1'b1, 1'b0, tac_pkg::TAC_ST_DEACTIVATED);
        xfer(8'h06, 8'h00, 1'b1, 1'b0, tac_pkg::TAC_ST_DEACTIVATED);
    endtask

    initial begin
        reset_n_in = 1'b0;
        do_reset();
        t_ready();
        t_round();
        t_select();
        do_reset();
        t_ready();
        wrap_up();
    end

    // hang guard well above the expected run length
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            wrap_up();
        end
    end
endmodule // tb_tac_fsm
